// ===== thr_irq_pkg.sv
package thr_irq_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h89;
  localparam logic [7:0] ADDR_LO_THR_UPPER = 8'h8A;
  localparam logic [7:0] ADDR_LO_THR_LOWER = 8'h8B;
  localparam logic [7:0] ADDR_HI_THR_UPPER = 8'h8C;
  localparam logic [7:0] ADDR_HI_THR_LOWER = 8'h8D;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h8E;

  // ----------------------------------------------------------------
  // Interrupt flag positions
  // ----------------------------------------------------------------
  localparam int FLAG_PROX_DONE = 3;
  localparam int FLAG_ALS_DONE = 2;
  localparam int FLAG_BELOW_FLOOR = 1;
  localparam int FLAG_ABOVE_CEILING = 0;
  localparam logic [7:0] FLAGS_USED_MASK = 8'h0F;

  // ----------------------------------------------------------------
  // Interrupt control fields
  // ----------------------------------------------------------------
  localparam int CTRL_SOURCE_SELECT = 0;
  localparam int CTRL_COMPARE_EN = 1;
  localparam int CTRL_ALS_READY_EN = 2;
  localparam int CTRL_PROX_READY_EN = 3;
  localparam int CTRL_PERSIST_LSB = 5;
  localparam logic [7:0] CTRL_USED_MASK = 8'hEF;

  // ----------------------------------------------------------------
  // Reset values and persistence
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] THR_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] PERSIST_BASE = 8'h01;
  localparam logic [7:0] PERSIST_CNT_RESET = 8'h00;

endpackage

// ===== persist_counter.sv
`timescale 1ns/10ps
module persist_counter
  import thr_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic sample_i,
  input wire logic outside_i,
  input wire logic [2:0] persist_code_i,
  output logic fire_o
);

  typedef struct packed {
    logic [7:0] cnt;
  } persist_state_s;

  persist_state_s st_r;
  persist_state_s st_nxt;
  logic [7:0] limit;
  logic [7:0] cnt_inc;

  // ----------------------------------------------------------------
  // Consecutive out-of-range counter
  // ----------------------------------------------------------------
  assign limit = PERSIST_BASE << persist_code_i;
  assign cnt_inc = st_r.cnt + 8'h01;
  assign fire_o = ce_i && sample_i && outside_i && (cnt_inc >= limit);

  always_comb begin
    st_nxt = st_r;
    if (sample_i) begin
      // An in-range sample breaks the run; a fire restarts it
      if (!outside_i || fire_o) begin
        st_nxt.cnt = PERSIST_CNT_RESET;
      end else begin
        st_nxt.cnt = cnt_inc;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '{cnt: PERSIST_CNT_RESET};
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  no_fire_inside_a: assert property (fire_o |-> outside_i && sample_i)
    else $error("persistence fired on an in-range sample");
  run_resets_a: assert property (ce_i && sample_i && !outside_i |=> st_r.cnt == 8'h00)
    else $error("persistence run not cleared by in-range sample");
  count_one_a: assert property (persist_code_i == 3'h0 && ce_i && sample_i && outside_i |-> fire_o)
    else $error("single count persistence did not fire");

endmodule // persist_counter

// ===== threshold_interrupt_logic.sv
`timescale 1ns/10ps
module threshold_interrupt_logic
  import thr_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [15:0] prox_result_i,
  input wire logic prox_ready_i,
  input wire logic [15:0] als_result_i,
  input wire logic als_ready_i,
  output logic int_pad_o,
  output logic int_pad_oe_n_o
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] lo_thr;
    logic [15:0] hi_thr;
    logic [7:0] flags;
    logic [7:0] rdata;
  } thr_state_s;

  thr_state_s st_r;
  thr_state_s st_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic sel_als;
  logic sample;
  logic [15:0] sample_val;
  logic below;
  logic above;
  logic fire;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // Threshold comparison
  // ----------------------------------------------------------------
  assign sel_als = st_r.ctrl[CTRL_SOURCE_SELECT];
  assign sample = sel_als ? als_ready_i : prox_ready_i;
  assign sample_val = sel_als ? als_result_i : prox_result_i;
  assign below = sample_val < st_r.lo_thr;
  assign above = sample_val > st_r.hi_thr;

  persist_counter u_persist (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .sample_i(sample),
    .outside_i(below || above),
    .persist_code_i(st_r.ctrl[CTRL_PERSIST_LSB +: 3]),
    .fire_o(fire)
  );

  // ----------------------------------------------------------------
  // Flag set and clear
  // ----------------------------------------------------------------
  always_comb begin
    set_bits = 8'h00;
    set_bits[FLAG_PROX_DONE] = prox_ready_i && st_r.ctrl[CTRL_PROX_READY_EN];
    set_bits[FLAG_ALS_DONE] = als_ready_i && st_r.ctrl[CTRL_ALS_READY_EN];
    set_bits[FLAG_BELOW_FLOOR] = fire && below && st_r.ctrl[CTRL_COMPARE_EN];
    set_bits[FLAG_ABOVE_CEILING] = fire && above && st_r.ctrl[CTRL_COMPARE_EN];
  end
  assign clr_bits = (reg_wr_i && reg_addr_i == ADDR_IRQ_FLAGS) ? reg_wdata_i : 8'h00;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // A set in the clearing cycle wins so no event is lost
    st_nxt.flags = ((st_r.flags & ~clr_bits) | set_bits) & FLAGS_USED_MASK;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_IRQ_CTRL: st_nxt.ctrl = reg_wdata_i & CTRL_USED_MASK;
        ADDR_LO_THR_UPPER: st_nxt.lo_thr[15:8] = reg_wdata_i;
        ADDR_LO_THR_LOWER: st_nxt.lo_thr[7:0] = reg_wdata_i;
        ADDR_HI_THR_UPPER: st_nxt.hi_thr[15:8] = reg_wdata_i;
        ADDR_HI_THR_LOWER: st_nxt.hi_thr[7:0] = reg_wdata_i;
        default: st_nxt.ctrl = st_nxt.ctrl;
      endcase
    end
    case (reg_addr_i)
      ADDR_IRQ_CTRL: st_nxt.rdata = st_r.ctrl;
      ADDR_LO_THR_UPPER: st_nxt.rdata = st_r.lo_thr[15:8];
      ADDR_LO_THR_LOWER: st_nxt.rdata = st_r.lo_thr[7:0];
      ADDR_HI_THR_UPPER: st_nxt.rdata = st_r.hi_thr[15:8];
      ADDR_HI_THR_LOWER: st_nxt.rdata = st_r.hi_thr[7:0];
      ADDR_IRQ_FLAGS: st_nxt.rdata = st_r.flags;
      default: st_nxt.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{ctrl: CTRL_RESET, lo_thr: THR_RESET, hi_thr: THR_RESET, flags: FLAGS_RESET, rdata: 8'h00};
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  // Open-drain pin: low level is only ever driven, never high
  assign int_pad_o = 1'b0;
  assign int_pad_oe_n_o = ~(|st_r.flags);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  pin_follows_flags_a: assert property (int_pad_oe_n_o == (st_r.flags == 8'h00))
    else $error("interrupt pin does not follow flags");
  pad_low_only_a: assert property (int_pad_o == 1'b0)
    else $error("interrupt pad would drive high");
  flags_upper_zero_a: assert property (st_r.flags[7:4] == 4'h0)
    else $error("unused flag bits set");
  ctrl_unused_zero_a: assert property ((st_r.ctrl & ~CTRL_USED_MASK) == 8'h00)
    else $error("unused control bit set");
  flag_sticks_a: assert property (ce_i && st_r.flags[FLAG_PROX_DONE] && !clr_bits[FLAG_PROX_DONE]
      |=> st_r.flags[FLAG_PROX_DONE])
    else $error("flag dropped without a clearing write");
  zero_write_keeps_a: assert property (ce_i && reg_wr_i && reg_addr_i == ADDR_IRQ_FLAGS
      && !reg_wdata_i[FLAG_BELOW_FLOOR] && st_r.flags[FLAG_BELOW_FLOOR] |=> st_r.flags[FLAG_BELOW_FLOOR])
    else $error("writing zero cleared a flag");
  one_write_clears_a: assert property (ce_i && clr_bits[FLAG_BELOW_FLOOR] && !set_bits[FLAG_BELOW_FLOOR]
      |=> !st_r.flags[FLAG_BELOW_FLOOR])
    else $error("writing one did not clear a flag");
  set_beats_clear_a: assert property (ce_i && set_bits[FLAG_ALS_DONE] |=> st_r.flags[FLAG_ALS_DONE])
    else $error("flag lost on simultaneous clear");
  prox_ready_sets_a: assert property (ce_i && prox_ready_i && st_r.ctrl[CTRL_PROX_READY_EN]
      |=> st_r.flags[FLAG_PROX_DONE])
    else $error("proximity done flag not set");
  als_ready_sets_a: assert property (ce_i && als_ready_i && st_r.ctrl[CTRL_ALS_READY_EN]
      |=> st_r.flags[FLAG_ALS_DONE])
    else $error("ambient done flag not set");
  ready_gated_a: assert property (ce_i && prox_ready_i && !st_r.ctrl[CTRL_PROX_READY_EN]
      && !st_r.flags[FLAG_PROX_DONE] |=> !st_r.flags[FLAG_PROX_DONE])
    else $error("ready flag set while disabled");
  compare_gated_a: assert property (ce_i && !st_r.ctrl[CTRL_COMPARE_EN] && !st_r.flags[FLAG_BELOW_FLOOR]
      |=> !st_r.flags[FLAG_BELOW_FLOOR])
    else $error("threshold flag set while compare disabled");
  above_gated_a: assert property (ce_i && !st_r.ctrl[CTRL_COMPARE_EN] && !st_r.flags[FLAG_ABOVE_CEILING]
      |=> !st_r.flags[FLAG_ABOVE_CEILING])
    else $error("above ceiling flag set while compare disabled");
  prox_source_a: assert property (!sel_als && !prox_ready_i |-> !fire)
    else $error("proximity selected but counted without its ready");
  als_source_a: assert property (sel_als && !als_ready_i |-> !fire)
    else $error("ambient selected but counted without its ready");
  in_range_quiet_a: assert property (!below && !above
      |-> !set_bits[FLAG_BELOW_FLOOR] && !set_bits[FLAG_ABOVE_CEILING])
    else $error("threshold flag set by an in-range result");
  below_sets_a: assert property (ce_i && fire && below && st_r.ctrl[CTRL_COMPARE_EN]
      |=> st_r.flags[FLAG_BELOW_FLOOR])
    else $error("below floor flag not set");
  above_sets_a: assert property (ce_i && fire && above && st_r.ctrl[CTRL_COMPARE_EN]
      |=> st_r.flags[FLAG_ABOVE_CEILING])
    else $error("above ceiling flag not set");
  lo_hold_a: assert property (!reg_wr_i |=> $stable(st_r.lo_thr))
    else $error("low threshold changed without a write");
  hi_hold_a: assert property (!reg_wr_i |=> $stable(st_r.hi_thr))
    else $error("high threshold changed without a write");
  ctrl_hold_a: assert property (!reg_wr_i |=> $stable(st_r.ctrl))
    else $error("control changed without a write");
  lo_lower_write_a: assert property (ce_i && reg_wr_i && reg_addr_i == ADDR_LO_THR_LOWER
      |=> st_r.lo_thr[7:0] == $past(reg_wdata_i))
    else $error("low threshold lower byte not written");
  hi_upper_write_a: assert property (ce_i && reg_wr_i && reg_addr_i == ADDR_HI_THR_UPPER
      |=> st_r.hi_thr[15:8] == $past(reg_wdata_i))
    else $error("high threshold upper byte not written");
  // Read data lags the address by one enabled edge
  lo_readback_a: assert property (ce_i && reg_wr_i && reg_addr_i == ADDR_LO_THR_UPPER ##1
      ce_i && !reg_wr_i && reg_addr_i == ADDR_LO_THR_UPPER |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("low threshold upper byte readback wrong");
  hi_readback_a: assert property (ce_i && reg_wr_i && reg_addr_i == ADDR_HI_THR_LOWER ##1
      ce_i && !reg_wr_i && reg_addr_i == ADDR_HI_THR_LOWER |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("high threshold lower byte readback wrong");
  status_read_a: assert property (ce_i && reg_addr_i == ADDR_IRQ_FLAGS |=> reg_rdata_o == $past(st_r.flags))
    else $error("status read wrong");
  // The reset synchroniser sits outside the struct and keeps running while frozen
  ce_freeze_a: assert property (!ce_i |=> $stable(st_r))
    else $error("state changed while clock enable low");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  pin_asserted_c: cover property (ce_i && !int_pad_oe_n_o ##1 int_pad_oe_n_o);
  threshold_fire_c: cover property (set_bits[FLAG_ABOVE_CEILING] && sel_als);
  persist_long_c: cover property (fire && st_r.ctrl[CTRL_PERSIST_LSB +: 3] == 3'h7);
  set_clear_clash_c: cover property (ce_i && set_bits[FLAG_ALS_DONE] && clr_bits[FLAG_ALS_DONE]);
  enable_frozen_c: cover property (!ce_i && reg_wr_i);

endmodule // threshold_interrupt_logic

// ===== int_line_pullup.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host side of the interrupt line
// ----------------------------------------------------------------
module int_line_pullup (
  input wire logic pad_i,
  input wire logic pad_oe_n_i,
  output logic line_o
);
  // Open-drain net with a pull-up, so a released pad must read high, never the last driven value
  assign line_o = pad_oe_n_i ? 1'b1 : pad_i;
endmodule // int_line_pullup

// ===== threshold_interrupt_logic_bench.sv
`timescale 1ns/10ps
module threshold_interrupt_logic_bench
  import thr_irq_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic [15:0] prox_result_i = 16'h0000;
  logic prox_ready_i = 1'b0;
  logic [15:0] als_result_i = 16'h0000;
  logic als_ready_i = 1'b0;
  logic int_pad_o;
  logic int_pad_oe_n_o;
  logic int_line;
  int miscompares = 0;
  int samples_checked = 0;

  threshold_interrupt_logic DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .prox_result_i(prox_result_i),
    .prox_ready_i(prox_ready_i), .als_result_i(als_result_i), .als_ready_i(als_ready_i),
    .int_pad_o(int_pad_o), .int_pad_oe_n_o(int_pad_oe_n_o));
  int_line_pullup host (.pad_i(int_pad_o), .pad_oe_n_i(int_pad_oe_n_o), .line_o(int_line));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks, entered and left at a falling edge
  // ----------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: interrupt line %b expected %b", $time, got, exp);
    end
  endtask

  // An idle edge follows each strobe so back-to-back calls never re-raise it in one step
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Read data is registered, so it is valid one edge after the address
  task automatic read_expect(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    @(negedge clk_i);
    check8(reg_rdata_o, exp);
  endtask

  // Both results carry the value; only the pulsed source is a real sample
  task automatic sample(input logic als, input logic [15:0] val);
    prox_result_i = val;
    als_result_i = val;
    prox_ready_i = ~als;
    als_ready_i = als;
    @(negedge clk_i);
    prox_ready_i = 1'b0;
    als_ready_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic flags_expect(input logic [7:0] exp);
    read_expect(ADDR_IRQ_FLAGS, exp);
    check1(int_line, exp == 8'h00);
  endtask

  task automatic test_done();
    $display("miscompares %0d, samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < 5; i++) begin
      read_expect(ADDR_LO_THR_UPPER + 8'(i), 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      reg_write(ADDR_LO_THR_UPPER + 8'(i), 8'h12 + 8'(i) * 8'h22);
    end
    for (int i = 0; i < 4; i++) begin
      read_expect(ADDR_LO_THR_UPPER + 8'(i), 8'h12 + 8'(i) * 8'h22);
    end
    reg_write(8'h90, 8'hFF);
    read_expect(8'h90, 8'h00);
    reg_write(ADDR_IRQ_CTRL, 8'hFF);
    read_expect(ADDR_IRQ_CTRL, 8'hEF);
    reg_write(ADDR_IRQ_CTRL, 8'h06);
    sample(1'b1, 16'h0000);
    sample(1'b0, 16'h0000);
    flags_expect(8'h06);
    reg_write(ADDR_IRQ_FLAGS, 8'h00);
    flags_expect(8'h06);
    reg_write(ADDR_IRQ_FLAGS, 8'h02);
    flags_expect(8'h04);
    reg_write(ADDR_IRQ_FLAGS, 8'h04);
    flags_expect(8'h00);
    sample(1'b0, 16'hFFFF);
    flags_expect(8'h01);
    reg_write(ADDR_IRQ_FLAGS, 8'h01);
    // Values equal to a threshold are not out of range
    sample(1'b0, 16'h1234);
    sample(1'b0, 16'h5678);
    flags_expect(8'h00);
    reg_write(ADDR_IRQ_CTRL, 8'h05);
    sample(1'b1, 16'h0000);
    flags_expect(8'h04);
    reg_write(ADDR_IRQ_FLAGS, 8'h04);
    reg_write(ADDR_IRQ_CTRL, 8'h0B);
    sample(1'b0, 16'h0000);
    flags_expect(8'h08);
    sample(1'b1, 16'hFFFF);
    flags_expect(8'h09);
    reg_write(ADDR_IRQ_FLAGS, 8'h09);
    reg_write(ADDR_IRQ_CTRL, 8'h23);
    sample(1'b1, 16'h0000);
    flags_expect(8'h00);
    sample(1'b1, 16'h0000);
    flags_expect(8'h02);
    reg_write(ADDR_IRQ_FLAGS, 8'h02);
    sample(1'b1, 16'h0000);
    sample(1'b1, 16'h3000);
    sample(1'b1, 16'h0000);
    flags_expect(8'h00);
    sample(1'b1, 16'h0000);
    flags_expect(8'h02);
    reg_write(ADDR_IRQ_CTRL, 8'h0F);
    sample(1'b1, 16'h0000);
    sample(1'b1, 16'hFFFF);
    sample(1'b0, 16'h0000);
    flags_expect(8'h0F);
    reg_write(ADDR_IRQ_FLAGS, 8'hFF);
    flags_expect(8'h00);
    // A clearing write that meets a new ready event must keep the flag
    reg_addr_i = ADDR_IRQ_FLAGS;
    reg_wdata_i = 8'h04;
    reg_wr_i = 1'b1;
    als_result_i = 16'h2000;
    als_ready_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    als_ready_i = 1'b0;
    @(negedge clk_i);
    flags_expect(8'h04);
    reg_write(ADDR_IRQ_FLAGS, 8'h04);
    // Nothing may move while the clock enable is low
    ce_i = 1'b0;
    reg_write(ADDR_LO_THR_UPPER, 8'hAA);
    sample(1'b1, 16'h0000);
    ce_i = 1'b1;
    read_expect(ADDR_LO_THR_UPPER, 8'h12);
    flags_expect(8'h00);
    reg_write(ADDR_IRQ_CTRL, 8'hE3);
    repeat (127) sample(1'b1, 16'h0000);
    flags_expect(8'h00);
    sample(1'b1, 16'h0000);
    flags_expect(8'h02);
    test_done();
  end

  // Whole run is about 380 cycles, so 1000 leaves a wide margin
  initial begin
    #100000;
    miscompares++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    test_done();
  end
endmodule // threshold_interrupt_logic_bench
